// >>> fhd_pkg.sv
// Shared constants and carrier types for the fixed-head disc channel.
// Assumes a single 250 MHz controller clock; disc pins arrive asynchronously.
`default_nettype none
package fhd_pkg;
  // ------------------------------------------------------------
  // Host instruction decoding
  // ------------------------------------------------------------
  localparam logic [5:0] DEV_ADDR = 6'h12;      // Device address 22 octal
  localparam logic [3:0] FN_SKS_READY = 4'h0;
  localparam logic [3:0] FN_SKS_NOT_BUSY = 4'h1;
  localparam logic [3:0] FN_SKS_NO_DTE = 4'h2;
  localparam logic [3:0] FN_SKS_NO_AERR = 4'h3;
  localparam logic [3:0] FN_SKS_NO_INT = 4'h4;
  localparam logic [3:0] FN_OCP_SEL_CHAN = 4'h3;
  localparam logic [3:0] FN_OCP_STOP = 4'h4;
  localparam logic [3:0] FN_OCP_SEL_BUS = 4'h7;
  localparam logic [3:0] FN_INA_PLAIN = 4'h0;
  localparam logic [3:0] FN_INA_CLEAR = 4'h8;   // Function 10 octal
  localparam int WORD_W = 16;
  localparam int MASK_IDX = 8;                  // Accumulator bit 8, bit 1 is the MSB

  // ------------------------------------------------------------
  // Disc geometry and setup word fields
  // ------------------------------------------------------------
  localparam logic [11:0] CHARS_PER_TRACK = 12'hC00;  // 3072 character addresses
  localparam int TRACK_W = 6;                         // 64 tracks per surface
  localparam int UNIT_W = 3;
  localparam int UNITS = 8;
  localparam int SU_WRITE_IDX = 15;
  localparam int SU_UNIT_LSB = 8;
  localparam int SU_TRACK_LSB = 0;
  localparam int SU_CHAR_LSB = 0;
  localparam logic [2:0] LAST_CBIT = 3'h7;
  localparam logic [3:0] LAST_WBIT = 4'hF;
  localparam logic [3:0] GAP_END = 4'h8;
  localparam logic [6:0] HOLDOFF_BITS = 7'h46;        // 70 bit times
  localparam logic [2:0] TAIL_WR_CHARS = 3'h1;        // Ends after two more characters
  localparam logic [2:0] TAIL_RD_CHARS = 3'h0;        // Ends within one character

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_SETUP1 = 3'b001,
    ST_SETUP2 = 3'b010,
    ST_SEARCH = 3'b011,
    ST_XFER = 3'b100,
    ST_RGAP = 3'b101,
    ST_WGAP = 3'b110,
    ST_TAIL = 3'b111
  } fhd_state_t;

  typedef struct packed {
    logic output_control_pulse;
    logic skip_on_status_instr;
    logic input_to_accumulator_instr;
    logic output_from_accumulator_instr;
    logic set_interrupt_mask_instr;
    logic [3:0] fn;
    logic [5:0] dev;
    logic [WORD_W-1:0] data;
  } fhd_cmd_t;

  typedef struct packed {
    logic skip;
    logic [WORD_W-1:0] data;
    logic program_interrupt_line;
    logic ready;
  } fhd_rsp_t;

  typedef struct packed {
    logic bit_clk;
    logic origin;
    logic rd_data;
    logic [UNITS-1:0] present;
    logic [UNITS-1:0] wr_dis;
  } fhd_disc_in_t;

  typedef struct packed {
    logic wr_data;
    logic wr_gate;
    logic [UNIT_W-1:0] unit;
    logic [TRACK_W-1:0] track;
  } fhd_disc_out_t;

  typedef struct packed {
    fhd_state_t state;
    fhd_disc_in_t p1;
    fhd_disc_in_t p2;
    logic clk_d;
    logic org_d;
    fhd_rsp_t rsp;
    fhd_disc_out_t dout;
    logic busy;
    logic ready;
    logic dma;
    logic write;
    logic aerr;
    logic dte;
    logic lost_sync;
    logic stop;
    logic mask;
    logic int_pend;
    logic buf_full;
    logic par;
    logic first_bit;
    logic [WORD_W-1:0] buf_w;
    logic [WORD_W-1:0] sh;
    logic [3:0] wbit;
    logic [2:0] cbit;
    logic [11:0] caddr;
    logic [11:0] start;
    logic [6:0] hold;
    logic [2:0] tail;
  } fhd_st_t;
endpackage
`default_nettype wire

// >>> fhd_channel.sv
// Fixed-head disc channel: host instruction decode, setup, search and serial record transfer.
// Host strobes are synchronous to CLK; disc pins are synchronised here.
// Operation
// - 8-bit characters, 3072 addresses, 64 tracks.
// - Serial word order is bit 1 first.
// - Record ends in gap carrying even parity.
// - Write fills two characters per output word.
// - Late output word ends write with gap.
// - Track origin stops transfer in both modes.
// - Late input word makes next character gap.
// - Set-mask loads mask from accumulator bit 8.
// - Input skips and transfers only when ready.
// - Output always skips; MSB written first.
// - Channel select pulse starts setup then data.
// - Bus select pulse starts setup then data.
// - Masked interrupt from not-busy; acknowledge clears.
// - Ready skip whenever a word is acceptable.
// - Busy from select to end or error.
// - Busy clears shortly after last word.
// - Read parity check sets transfer error.
// - Stop after lost sync flags timing error.
// - Access error clears busy, persists with condition.
// - Setup is select plus two output words.
// - No data exchange 70 bit times into search, except a write's first word.
`timescale 1ns/1ns
`default_nettype none

module fhd_channel (
  // Clock and reset
  input wire logic CLK,
  input wire logic NRST,
  // Host instruction strobes and channel end
  input wire fhd_pkg::fhd_cmd_t HOST_CMD,
  input wire logic CHAN_END,
  // Host answers
  output var fhd_pkg::fhd_rsp_t HOST_RSP,
  // Disc unit pins
  input wire fhd_pkg::fhd_disc_in_t DISC_IN,
  output var fhd_pkg::fhd_disc_out_t DISC_OUT
);
  // ------------------------------------------------------------
  // Reset release
  // ------------------------------------------------------------
  logic rst_s1_r;
  logic rst_n;

  // Asynchronous assert, release through two flops
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      rst_s1_r <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_s1_r <= 1'b1;
      rst_n <= rst_s1_r;
    end
  end

  // ------------------------------------------------------------
  // State and decode
  // ------------------------------------------------------------
  fhd_pkg::fhd_st_t s_r;
  fhd_pkg::fhd_st_t s_nxt;
  logic bit_stb;
  logic org_stb;
  logic rd_bit;
  logic hit;
  logic sel_hit;
  logic stop_ocp;
  logic stop_ev;
  logic aerr_cond;
  logic [fhd_pkg::WORD_W-1:0] rd_word;

  // Strobes come only from the second sync stage, never the first
  assign bit_stb = s_r.p2.bit_clk & ~s_r.clk_d;
  assign org_stb = s_r.p2.origin & ~s_r.org_d;
  assign rd_bit = s_r.p2.rd_data;
  assign rd_word = {s_r.sh[fhd_pkg::WORD_W-2:0], rd_bit};
  assign hit = HOST_CMD.dev == fhd_pkg::DEV_ADDR;
  assign sel_hit = HOST_CMD.output_control_pulse && hit && (HOST_CMD.fn == fhd_pkg::FN_OCP_SEL_CHAN ||
                   HOST_CMD.fn == fhd_pkg::FN_OCP_SEL_BUS);
  assign stop_ocp = HOST_CMD.output_control_pulse && hit && HOST_CMD.fn == fhd_pkg::FN_OCP_STOP;
  // Bus mode ends by the stop pulse, channel modes by channel end
  assign stop_ev = s_r.busy && ((stop_ocp && !s_r.dma) || (CHAN_END && s_r.dma));
  // Missing unit, write-locked unit or address beyond the track
  assign aerr_cond = !s_r.p2.present[s_r.dout.unit] ||
                     (s_r.write && s_r.p2.wr_dis[s_r.dout.unit]) ||
                     s_r.start >= fhd_pkg::CHARS_PER_TRACK;

  // Next-state logic: pins, host, disc sequencer, stop, select
  always_comb begin
    s_nxt = s_r;
    s_nxt.p1 = DISC_IN;
    s_nxt.p2 = s_r.p1;
    s_nxt.clk_d = s_r.p2.bit_clk;
    s_nxt.org_d = s_r.p2.origin;
    s_nxt.rsp.skip = 1'b0;

    // Character position from track origin
    if (org_stb) begin
      s_nxt.cbit = '0;
      s_nxt.caddr = '0;
    end else if (bit_stb) begin
      s_nxt.cbit = s_r.cbit + 3'h1;
      if (s_r.cbit == fhd_pkg::LAST_CBIT && s_r.caddr != fhd_pkg::CHARS_PER_TRACK) begin
        s_nxt.caddr = s_r.caddr + 12'h001;
      end
    end

    // Mask takes accumulator bit 8
    if (HOST_CMD.set_interrupt_mask_instr) begin
      s_nxt.mask = HOST_CMD.data[fhd_pkg::WORD_W-fhd_pkg::MASK_IDX];
    end

    // Status skips
    if (HOST_CMD.skip_on_status_instr && hit) begin
      case (HOST_CMD.fn)
        fhd_pkg::FN_SKS_READY: s_nxt.rsp.skip = s_r.ready;
        fhd_pkg::FN_SKS_NOT_BUSY: s_nxt.rsp.skip = !s_r.busy;
        fhd_pkg::FN_SKS_NO_DTE: s_nxt.rsp.skip = !s_r.dte;
        fhd_pkg::FN_SKS_NO_AERR: s_nxt.rsp.skip = !s_r.aerr;
        fhd_pkg::FN_SKS_NO_INT: s_nxt.rsp.skip = !s_r.rsp.program_interrupt_line;
        default: s_nxt.rsp.skip = 1'b0;
      endcase
    end

    // Output word: setup words first, then data into the buffer
    if (HOST_CMD.output_from_accumulator_instr && hit) begin
      s_nxt.rsp.skip = 1'b1;
      if (s_r.state == fhd_pkg::ST_SETUP1) begin
        s_nxt.write = HOST_CMD.data[fhd_pkg::SU_WRITE_IDX];
        s_nxt.dout.unit = HOST_CMD.data[fhd_pkg::SU_UNIT_LSB +: fhd_pkg::UNIT_W];
        s_nxt.dout.track = HOST_CMD.data[fhd_pkg::SU_TRACK_LSB +: fhd_pkg::TRACK_W];
        s_nxt.state = fhd_pkg::ST_SETUP2;
      end else if (s_r.state == fhd_pkg::ST_SETUP2) begin
        s_nxt.start = HOST_CMD.data[fhd_pkg::SU_CHAR_LSB +: $bits(s_nxt.start)];
        s_nxt.hold = fhd_pkg::HOLDOFF_BITS;
        s_nxt.state = fhd_pkg::ST_SEARCH;
        s_nxt.ready = s_r.write; // Write needs its first word before the search
      end else if (s_r.ready && s_r.write) begin
        s_nxt.buf_w = HOST_CMD.data;
        s_nxt.buf_full = 1'b1;
        s_nxt.ready = 1'b0;
      end
    end

    // Input word only when a word is waiting; parity taken as it leaves
    if (HOST_CMD.input_to_accumulator_instr && hit && (HOST_CMD.fn == fhd_pkg::FN_INA_PLAIN ||
        HOST_CMD.fn == fhd_pkg::FN_INA_CLEAR)) begin
      if (s_r.ready && !s_r.write && s_r.buf_full) begin
        s_nxt.rsp.skip = 1'b1;
        s_nxt.rsp.data = s_r.buf_w;
        s_nxt.buf_full = 1'b0;
        s_nxt.ready = 1'b0;
        s_nxt.par = s_r.par ^ (^s_r.buf_w);
      end
    end

    // Disc sequencer; buffer state is the one left by the host this cycle
    unique case (s_r.state)
      fhd_pkg::ST_IDLE, fhd_pkg::ST_SETUP1, fhd_pkg::ST_SETUP2: begin
        if (s_r.aerr && !aerr_cond) begin
          s_nxt.aerr = 1'b0;
        end
      end
      fhd_pkg::ST_SEARCH: begin
        // Holdoff only runs once a write has its first word
        if (bit_stb && s_r.hold != '0 && (!s_r.write || s_nxt.buf_full)) begin
          s_nxt.hold = s_r.hold - 7'h01;
        end
        if (s_r.write && s_nxt.buf_full) begin
          s_nxt.ready = 1'b0;
        end
        if (s_r.hold == '0 && s_r.cbit == '0 && s_r.caddr == s_r.start &&
            (!s_r.write || s_nxt.buf_full)) begin
          s_nxt.state = fhd_pkg::ST_XFER;
          s_nxt.wbit = '0;
          s_nxt.par = 1'b0;
          if (s_r.write) begin
            s_nxt.sh = s_nxt.buf_w;
            s_nxt.buf_full = 1'b0;
            s_nxt.ready = 1'b1;
          end
        end
      end
      fhd_pkg::ST_XFER: begin
        if (org_stb) begin
          s_nxt.lost_sync = 1'b1;
          s_nxt.ready = 1'b0;
          s_nxt.dout.wr_gate = 1'b0;
          s_nxt.state = fhd_pkg::ST_TAIL;
          s_nxt.tail = fhd_pkg::TAIL_RD_CHARS;
        end else if (bit_stb) begin
          s_nxt.wbit = s_r.wbit + 4'h1;
          if (s_r.write) begin
            // Bit 1 (MSB) leaves first
            s_nxt.dout.wr_gate = 1'b1;
            s_nxt.dout.wr_data = s_r.sh[fhd_pkg::WORD_W-1];
            s_nxt.par = s_r.par ^ s_r.sh[fhd_pkg::WORD_W-1];
            s_nxt.sh = {s_r.sh[fhd_pkg::WORD_W-2:0], 1'b0};
            if (s_r.wbit == fhd_pkg::LAST_WBIT) begin
              if (s_nxt.buf_full) begin
                s_nxt.sh = s_nxt.buf_w;
                s_nxt.buf_full = 1'b0;
                s_nxt.ready = !s_r.stop;
              end else begin
                // Late or absent word closes the record with a gap
                s_nxt.state = fhd_pkg::ST_WGAP;
                s_nxt.wbit = '0;
                s_nxt.ready = 1'b0;
                s_nxt.lost_sync = s_r.lost_sync | !s_r.stop;
              end
            end
          end else begin
            s_nxt.sh = rd_word;
            if (s_r.wbit == '0) begin
              s_nxt.first_bit = rd_bit;
            end
            if (s_r.wbit == fhd_pkg::LAST_WBIT) begin
              if (s_nxt.buf_full) begin
                // Untaken word: its first character is the gap
                s_nxt.dte = s_r.dte | (s_nxt.buf_w[fhd_pkg::WORD_W-1] != s_r.par);
                s_nxt.lost_sync = 1'b1;
                s_nxt.buf_full = 1'b0;
                s_nxt.ready = 1'b0;
                s_nxt.state = fhd_pkg::ST_TAIL;
                s_nxt.tail = fhd_pkg::TAIL_RD_CHARS;
              end else begin
                s_nxt.buf_w = rd_word;
                s_nxt.buf_full = 1'b1;
                s_nxt.ready = 1'b1;
              end
            end
          end
        end
      end
      fhd_pkg::ST_RGAP: begin
        if (bit_stb) begin
          s_nxt.dte = s_r.dte | (rd_bit != s_r.par);
          s_nxt.state = fhd_pkg::ST_TAIL;
          s_nxt.tail = fhd_pkg::TAIL_RD_CHARS;
        end
      end
      fhd_pkg::ST_WGAP: begin
        // One full character: parity bit then seven zero bits
        if (bit_stb) begin
          s_nxt.wbit = s_r.wbit + 4'h1;
          s_nxt.dout.wr_data = (s_r.wbit == '0) ? s_r.par : 1'b0;
          if (s_r.wbit == fhd_pkg::GAP_END) begin
            s_nxt.dout.wr_gate = 1'b0;
            s_nxt.state = fhd_pkg::ST_TAIL;
            s_nxt.tail = fhd_pkg::TAIL_WR_CHARS;
          end
        end
      end
      fhd_pkg::ST_TAIL: begin
        if (bit_stb && s_r.cbit == fhd_pkg::LAST_CBIT) begin
          if (s_r.tail == '0) begin
            s_nxt.busy = 1'b0;
            s_nxt.state = fhd_pkg::ST_IDLE;
          end else begin
            s_nxt.tail = s_r.tail - 3'h1;
          end
        end
      end
    endcase

    // Access error aborts search or transfer
    if ((s_r.state == fhd_pkg::ST_SEARCH || s_r.state == fhd_pkg::ST_XFER) && aerr_cond) begin
      s_nxt.aerr = 1'b1;
      s_nxt.busy = 1'b0;
      s_nxt.ready = 1'b0;
      s_nxt.dout.wr_gate = 1'b0;
      s_nxt.state = fhd_pkg::ST_IDLE;
    end

    // Stop or channel end; a late stop after lost sync is a timing error
    if (stop_ocp) begin
      s_nxt.int_pend = 1'b0;
    end
    if (stop_ev) begin
      s_nxt.dte = s_nxt.dte | s_r.lost_sync;
      s_nxt.stop = 1'b1;
      s_nxt.ready = 1'b0;
      if (s_nxt.state == fhd_pkg::ST_XFER && !s_r.write) begin
        if (s_r.wbit != '0) begin
          s_nxt.dte = s_nxt.dte | (s_r.first_bit != s_r.par);
          s_nxt.state = fhd_pkg::ST_TAIL;
          s_nxt.tail = fhd_pkg::TAIL_RD_CHARS;
        end else begin
          s_nxt.state = fhd_pkg::ST_RGAP;
        end
      end
    end

    // Either select restarts the channel for setup words
    if (sel_hit) begin
      s_nxt.state = fhd_pkg::ST_SETUP1;
      s_nxt.busy = 1'b1;
      s_nxt.ready = 1'b1;
      s_nxt.dma = HOST_CMD.fn == fhd_pkg::FN_OCP_SEL_CHAN;
      s_nxt.dte = 1'b0;
      s_nxt.aerr = 1'b0;
      s_nxt.lost_sync = 1'b0;
      s_nxt.stop = 1'b0;
      s_nxt.int_pend = 1'b0;
      s_nxt.buf_full = 1'b0;
      s_nxt.dout.wr_gate = 1'b0;
    end

    // Falling busy raises the request; it beats an acknowledge in the same cycle
    if (s_r.busy && !s_nxt.busy) begin
      s_nxt.int_pend = 1'b1;
    end
    s_nxt.rsp.program_interrupt_line = s_nxt.int_pend & s_nxt.mask;
    s_nxt.rsp.ready = s_nxt.ready;
  end

  // Whole state in one register
  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign HOST_RSP = s_r.rsp;
  assign DISC_OUT = s_r.dout;

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!rst_n);

  sequence wr_slot;
    s_r.state == fhd_pkg::ST_XFER && s_r.write && bit_stb && !org_stb;
  endsequence
  sequence gap_first;
    s_r.state == fhd_pkg::ST_WGAP && bit_stb && s_r.wbit == '0 && !sel_hit;
  endsequence

  ota_skip_a: assert property (HOST_CMD.output_from_accumulator_instr && hit |=> s_r.rsp.skip)
    else $error("output instruction did not skip");
  ina_noskip_a: assert property (HOST_CMD.input_to_accumulator_instr && hit && !s_r.ready && !HOST_CMD.skip_on_status_instr
    && !HOST_CMD.output_from_accumulator_instr |=> !s_r.rsp.skip)
    else $error("input skipped while not ready");
  mask_load_a: assert property (HOST_CMD.set_interrupt_mask_instr |=> s_r.mask == $past(HOST_CMD.data[8]))
    else $error("mask not loaded from bit 8");
  busy_set_a: assert property (sel_hit |=> s_r.busy && s_r.state == fhd_pkg::ST_SETUP1)
    else $error("select did not set busy");
  pil_raise_a: assert property ($fell(s_r.busy) && s_r.mask |-> s_r.rsp.program_interrupt_line)
    else $error("interrupt missing after busy fell");
  ack_clear_a: assert property (stop_ocp && !s_r.busy && !sel_hit |=> !s_r.rsp.program_interrupt_line)
    else $error("acknowledge left interrupt active");
  bit_order_a: assert property (wr_slot |=> s_r.dout.wr_data == $past(s_r.sh[15]))
    else $error("serial bit order wrong");
  gap_parity_a: assert property (gap_first |=> s_r.dout.wr_data == $past(s_r.par)
    && s_r.dout.wr_gate)
    else $error("gap bit is not record parity");
  holdoff_a: assert property (s_r.state == fhd_pkg::ST_SEARCH && s_r.hold != '0
    && (s_r.buf_full || !s_r.write) |-> !s_r.ready)
    else $error("ready during search holdoff");
  origin_stop_a: assert property (s_r.state == fhd_pkg::ST_XFER && org_stb && !sel_hit
    |=> s_r.state == fhd_pkg::ST_TAIL ##1 !s_r.ready)
    else $error("origin did not stop transfer");
  aerr_busy_a: assert property ($rose(s_r.aerr) |-> !s_r.busy)
    else $error("access error left busy set");
endmodule

`default_nettype wire

// >>> fhd_disc_model.sv
// Disc unit model for the fixed-head disc channel bench.
// Assumes the channel synchronises every disc pin to its own clock.
`timescale 1ns/1ns
`default_nettype none
module fhd_disc_model (
  // Bench control
  input wire logic org_go,
  input wire logic [31:0] rd_w,
  input wire logic rd_par,
  input wire logic [11:0] base_ch,
  // Disc pins
  input wire fhd_pkg::fhd_disc_out_t dout,
  output var fhd_pkg::fhd_disc_in_t din,
  // Captured write stream
  output var logic [63:0] wbits,
  output var logic [7:0] wcnt
);
  // ----------------------------------------
  // Rotation, read image and write capture
  // ----------------------------------------
  int pos;
  int rel;
  logic org_pend;
  initial begin
    din = '0;
    din.present = 8'h7F; // Unit 7 is missing
    din.wr_dis = 8'h40; // Unit 6 is locked
    wbits = '0;
    wcnt = '0;
    pos = 0;
    org_pend = 1'b0;
  end
  // Free-running bit clock of twelve CLK periods, its edges on CLK falling edges
  always #24 din.bit_clk = ~din.bit_clk;
  always @(posedge org_go) begin
    org_pend = 1'b1;
    wcnt = 8'h00;
  end
  // Origin lands mid-slot so the next strobe is plainly bit 0 of char 0
  always @(negedge din.bit_clk) begin
    din.origin <= org_pend;
    if (org_pend) pos = 0;
    org_pend = 1'b0;
    rel = pos - 8 * int'(base_ch);
    if (rel >= 0 && rel < 32) din.rd_data <= rd_w[31 - rel];
    else if (rel == 32) din.rd_data <= rd_par;
    else din.rd_data <= ~din.rd_data; // Never a stale copy outside the record
  end
  always @(posedge din.bit_clk) pos = pos + 1;
  // Sample late: the channel updates the pin a few cycles after each slot
  always @(posedge din.bit_clk) begin
    #36;
    if (dout.wr_gate) begin
      wbits = {wbits[62:0], dout.wr_data};
      wcnt = wcnt + 8'h01;
    end
  end
endmodule
`default_nettype wire

// >>> fixed_head_disc_channel_test.sv
// Self-checking bench for the fixed-head disc channel.
// Assumes host strobes are one-cycle pulses and the disc model above.
`timescale 1ns/1ns
`default_nettype none
module fixed_head_disc_channel_test;
  localparam int k_ocp = 0;
  localparam int k_sks = 1;
  localparam int k_ina = 2;
  localparam int k_ota = 3;
  localparam int k_smk = 4;
  logic CLK = 1'b0;
  logic NRST = 1'b0;
  logic CHAN_END = 1'b0;
  logic org_go = 1'b0;
  logic rd_par = 1'b0;
  logic sk;
  logic [31:0] rd_w = '0;
  logic [31:0] w;
  logic [11:0] addr = 12'h00C;
  logic [63:0] wbits;
  logic [7:0] wcnt;
  fhd_pkg::fhd_cmd_t cmd = '0;
  fhd_pkg::fhd_rsp_t rsp;
  fhd_pkg::fhd_disc_in_t din;
  fhd_pkg::fhd_disc_out_t dout;
  int n_fail = 0;
  int checks_done = 0;
  int cyc = 0;
  int seed = 44;
  int i;
  fhd_channel fhd_channel_inst (.CLK(CLK), .NRST(NRST), .HOST_CMD(cmd),
    .CHAN_END(CHAN_END), .HOST_RSP(rsp), .DISC_IN(din), .DISC_OUT(dout));
  fhd_disc_model fhd_disc_model_inst (.org_go(org_go), .rd_w(rd_w), .rd_par(rd_par),
    .base_ch(addr), .dout(dout), .din(din), .wbits(wbits), .wcnt(wcnt));
  always #2 CLK = ~CLK;
  // ----------------------------------------
  // Checking and bus tasks
  // ----------------------------------------
  task automatic stop_test();
    $display("Comparisons %0d, mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic chk_b(input logic exp, input logic got);
    checks_done++;
    if (got !== exp) begin
      n_fail++;
      $display("ERROR t=%0t exp=%h got=%h", $time, exp, got);
    end
  endtask
  task automatic chk_w(input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      n_fail++;
      $display("ERROR t=%0t exp=%h got=%h", $time, exp, got);
    end
  endtask
  // Expected even parity bit of a record
  function automatic logic exp_par(input logic [31:0] d);
    return ^d;
  endfunction
  // One instruction; the skip pulse is looked for in the two cycles after it
  task automatic instr(input int k, input logic [3:0] fn, input logic [15:0] d,
                       output logic s);
    fhd_pkg::fhd_cmd_t c;
    c = '0;
    c.fn = fn;
    c.dev = fhd_pkg::DEV_ADDR;
    c.data = d;
    c.output_control_pulse = (k == k_ocp);
    c.skip_on_status_instr = (k == k_sks);
    c.input_to_accumulator_instr = (k == k_ina);
    c.output_from_accumulator_instr = (k == k_ota);
    c.set_interrupt_mask_instr = (k == k_smk);
    @(posedge CLK);
    cmd <= c;
    @(posedge CLK);
    cmd <= '0;
    @(posedge CLK);
    s = rsp.skip;
    @(posedge CLK);
    s = s | rsp.skip;
  endtask
  task automatic wait_rdy();
    int n;
    for (n = 0; n < 6000 && rsp.ready !== 1'b1; n++) @(posedge CLK);
    chk_b(1'b1, rsp.ready);
  endtask
  task automatic wait_idle();
    int n;
    sk = 1'b0;
    for (n = 0; n < 1500 && sk !== 1'b1; n++) instr(k_sks, 4'h1, '0, sk);
    chk_b(1'b1, sk);
  endtask
  task automatic pulse_org();
    @(posedge CLK);
    org_go <= 1'b1;
    @(posedge CLK);
    org_go <= 1'b0;
  endtask
  // Setup, data and stop of one record; the host honours ready at once
  task automatic record(input logic wr, input logic chan, input logic [2:0] unit,
                        input logic org_mid, input logic [31:0] wd);
    logic s;
    int j;
    instr(k_ocp, chan ? 4'h3 : 4'h7, '0, s);
    instr(k_ota, 4'h0, {wr, 4'h0, unit, 8'h05}, s);
    chk_b(1'b1, s);
    instr(k_ota, 4'h0, {4'h0, addr}, s);
    if (wr) instr(k_ota, 4'h0, wd[31:16], s);
    pulse_org();
    if (!wr) begin
      instr(k_ina, 4'h0, '0, s);
      chk_b(1'b0, s);
    end
    for (j = 0; j < 2; j++) begin
      wait_rdy();
      if (wr && j == 0) instr(k_ota, 4'h0, wd[15:0], s);
      if (!wr) begin
        instr(k_ina, j ? 4'h8 : 4'h0, '0, s);
        chk_b(1'b1, s);
        chk_w(j ? wd[15:0] : wd[31:16], {16'h0000, rsp.data});
      end
    end
    if (org_mid) begin
      pulse_org();
      repeat (60) @(posedge CLK);
    end
    if (chan) begin
      @(posedge CLK);
      CHAN_END <= 1'b1;
      @(posedge CLK);
      CHAN_END <= 1'b0;
    end else begin
      instr(k_ocp, 4'h4, '0, s);
    end
    wait_idle();
  endtask
  // ----------------------------------------
  // Main sequence and hang guard
  // ----------------------------------------
  always @(posedge CLK) begin
    cyc++;
    if (cyc == 40000) begin
      n_fail++;
      stop_test();
    end
  end
  initial begin
    repeat (4) @(posedge CLK);
    NRST <= 1'b1;
    repeat (3) @(posedge CLK);
    chk_b(1'b0, rsp.ready);
    chk_b(1'b0, rsp.program_interrupt_line);
    // Bus write of two random words with the mask on
    instr(k_smk, 4'h0, 16'h0100, sk);
    w = $random(seed);
    addr <= 12'h00C + 12'($random(seed) & 7);
    record(1'b1, 1'b0, 3'h2, 1'b0, w);
    chk_w({24'h000000, 8'h28}, {24'h000000, wcnt});
    chk_w(w, wbits[39:8]);
    chk_b(exp_par(w), wbits[7]);
    chk_w({23'h000000, 3'h2, 6'h05}, {23'h000000, dout.unit, dout.track});
    chk_b(1'b1, rsp.program_interrupt_line);
    instr(k_sks, 4'h4, '0, sk);
    chk_b(1'b0, sk);
    instr(k_ocp, 4'h4, '0, sk);
    instr(k_sks, 4'h4, '0, sk);
    chk_b(1'b1, sk);
    $display("Write test done");
    // Channel read with good parity, bus read with bad parity
    for (i = 0; i < 2; i++) begin
      w = $random(seed);
      rd_w <= w;
      rd_par <= exp_par(w) ^ (i != 0); // Second pass carries a bad parity bit
      record(1'b0, i == 0, 3'h1, 1'b0, w);
      instr(k_sks, 4'h2, '0, sk);
      chk_b(i == 0, sk);
    end
    $display("Read tests done");
    // Host falls behind: write underrun, then read overrun
    for (i = 0; i < 2; i++) begin
      w = $random(seed);
      rd_w <= w;
      instr(k_ocp, 4'h7, '0, sk);
      instr(k_ota, 4'h0, {i == 0, 4'h0, 3'h2, 8'h05}, sk);
      instr(k_ota, 4'h0, {4'h0, addr}, sk);
      if (i == 0) instr(k_ota, 4'h0, w[31:16], sk);
      pulse_org();
      wait_rdy();
      if (i == 1) begin
        instr(k_ina, 4'h0, '0, sk);
        chk_b(1'b1, sk);
        chk_w(w[31:16], {16'h0000, rsp.data});
      end
      wait_idle();
      if (i == 0) begin
        chk_w(32'h00000018, {24'h000000, wcnt});
        chk_w(w[31:16], {16'h0000, wbits[23:8]});
        chk_b(exp_par(w[31:16]), wbits[7]);
      end
      instr(k_sks, 4'h2, '0, sk);
      chk_b(i == 0 || w[15] == exp_par(w[31:16]), sk);
    end
    $display("Underrun and overrun tests done");
    // Missing unit, locked unit, address past the track end
    for (i = 0; i < 3; i++) begin
      instr(k_ocp, 4'h7, '0, sk);
      instr(k_ota, 4'h0, {i == 1, 4'h0, 3'(7 - i), 8'h05}, sk);
      instr(k_ota, 4'h0, {4'h0, (i == 2) ? fhd_pkg::CHARS_PER_TRACK : addr}, sk);
      if (i == 1) instr(k_ota, 4'h0, 16'hA5A5, sk);
      wait_idle();
      instr(k_sks, 4'h3, '0, sk);
      chk_b(1'b0, sk);
      instr(k_sks, 4'h2, '0, sk);
      chk_b(1'b1, sk);
    end
    $display("Access error tests done");
    // Origin inside a channel write with the mask off
    instr(k_smk, 4'h0, 16'h0000, sk);
    record(1'b1, 1'b1, 3'h3, 1'b1, $random(seed));
    instr(k_sks, 4'h2, '0, sk);
    chk_b(1'b0, sk);
    chk_b(1'b0, rsp.program_interrupt_line);
    $display("Origin test done");
    stop_test();
  end
endmodule
`default_nettype wire
